//--- logic/psp_device.sv
// parallel slave port: device end with internal cpu side
// What this block does
// - mode bit makes data port byte slave
// - external strobes work asynchronous to clock
// - mode repurposes three pins as strobes
// - controller sets strobe pin directions input
// - controller sets strobe pins digital
// - write when chip-select and write low
// - read when chip-select and read low
// - bit 7 flags received byte pending
// - bit 6 flags transmit byte unread
// - bit 5 overrun sticky until cleared
// - bit 4 mode select, resets zero
// - low four control bits read zero
// - port works only without external bus
`timescale 1ns/1ps
module psp_device (
    input wire logic aclk,
    input wire logic aresetn,
    psp_if.device pins,
    input wire logic ext_bus_active,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    output logic [7:0] slave_port_control_status,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    input wire logic data_rd,
    output logic [7:0] data_rdata,
    output logic slave_port_irq_flag
);
    import psp_pkg::*;

    typedef struct packed {
        logic [7:0] rx_byte;
        logic [7:0] tx_byte;
        logic rx_byte_pending;
        logic tx_byte_pending;
        logic rx_overrun;
        logic slave_mode_select;
        logic wr_act;
        logic rd_act;
        logic irq;
    } psp_dev_t;

    psp_dev_t st_q;
    psp_dev_t st_d;
    logic rd_n_s;
    logic wr_n_s;
    logic cs_n_s;
    logic port_on;
    logic wr_low;
    logic rd_low;
    logic [7:0] host_byte;

    // strobe synchronisers, and
    psp_sync u_sync_rd (.aclk(aclk), .aresetn(aresetn), .async_in(pins.rd_n), .sync_out(rd_n_s));
    psp_sync u_sync_wr (.aclk(aclk), .aresetn(aresetn), .async_in(pins.wr_n), .sync_out(wr_n_s));
    psp_sync u_sync_cs (.aclk(aclk), .aresetn(aresetn), .async_in(pins.cs_n), .sync_out(cs_n_s));

    // strobe decode, gated by mode and bus state
    assign port_on = st_q.slave_mode_select && !ext_bus_active;
    assign wr_low = port_on && !cs_n_s && !wr_n_s;
    assign rd_low = port_on && !cs_n_s && !rd_n_s;
    // released data lines float to the pull-up level
    assign host_byte = pins.data_host_oe ? pins.data_from_host : 8'hFF;

    // next-state logic
    always_comb begin
        st_d = st_q;
        st_d.irq = 1'b0;
        if (wr_low) begin
            st_d.wr_act = 1'b1;
            // byte taken at first detection; later cycles may trail the host release
            if (!st_q.wr_act) begin
                st_d.rx_byte = host_byte;
            end
        end else if (st_q.wr_act) begin
            // write completes on release
            st_d.wr_act = 1'b0;
            st_d.irq = 1'b1;
        end
        if (rd_low) begin
            st_d.rd_act = 1'b1;
        end else if (st_q.rd_act) begin
            st_d.rd_act = 1'b0;
            st_d.irq = 1'b1;
            st_d.tx_byte_pending = 1'b0;
        end
        // software write of the control register
        if (ctrl_wr) begin
            st_d.slave_mode_select = ctrl_wdata[PSP_BIT_MODE_SEL];
            if (!ctrl_wdata[PSP_BIT_RX_OVERRUN]) begin
                st_d.rx_overrun = 1'b0;
            end
        end
        // cpu data latch accesses
        if (data_rd) begin
            st_d.rx_byte_pending = 1'b0;
        end
        if (data_wr) begin
            st_d.tx_byte = data_wdata;
            st_d.tx_byte_pending = 1'b1;
        end
        // hardware sets win over clears
        if (!wr_low && st_q.wr_act) begin
            if (st_q.rx_byte_pending) begin
                st_d.rx_overrun = 1'b1;
            end
            st_d.rx_byte_pending = 1'b1;
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs, unimplemented bits zero
    assign slave_port_control_status = {st_q.rx_byte_pending, st_q.tx_byte_pending,
        st_q.rx_overrun, st_q.slave_mode_select, 4'h0};
    assign data_rdata = st_q.rx_byte;
    assign slave_port_irq_flag = st_q.irq;
    assign pins.data_from_dev = st_q.tx_byte;
    assign pins.data_dev_oe = rd_low;
endmodule

//--- logic/psp_host.sv
// external processor end: axi4-lite driven strobe generator
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module psp_host (
    input wire logic aclk,
    input wire logic aresetn,
    psp_if.host pins,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    import psp_pkg::*;

    typedef struct packed {
        psp_hstate_t fsm;
        logic is_read;
        logic [7:0] cnt;
        logic [7:0] wbyte;
        logic [7:0] rbyte;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } psp_host_st_t;

    psp_host_st_t st_q;
    psp_host_st_t st_d;
    logic busy;
    logic do_wr;
    logic [1:0] ev_done;

    assign busy = st_q.fsm != PSP_H_IDLE;
    assign do_wr = st_q.aw_got && st_q.w_got && !st_q.bvalid;
    // transfer-done events of this cycle, kept over a status read
    assign ev_done = (st_q.fsm != PSP_H_HOLD) ? 2'b00 : (st_q.is_read ? 2'b10 : 2'b01);

    // axi slave and strobe sequencer; strobes held low PSP_STROBE_CYC cycles
    always_comb begin
        st_d = st_q;
        if (s_axi_awvalid && !st_q.aw_got && !st_q.bvalid) begin
            st_d.aw_got = 1'b1;
            st_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_got && !st_q.bvalid) begin
            st_d.w_got = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb = s_axi_wstrb;
        end
        case (st_q.fsm)
            PSP_H_SETUP: begin
                st_d.fsm = PSP_H_STROBE;
                st_d.cnt = PSP_STROBE_CYC;
            end
            PSP_H_STROBE: begin
                st_d.cnt = st_q.cnt - 8'h01;
                if (st_q.cnt == 8'h01) begin
                    st_d.fsm = PSP_H_HOLD;
                    if (st_q.is_read) begin
                        // undriven lines read as the pull-up level
                        st_d.rbyte = pins.data_dev_oe ? pins.data_from_dev : 8'hFF;
                    end
                end
            end
            PSP_H_HOLD: begin
                st_d.fsm = PSP_H_IDLE;
                if (st_q.is_read) begin
                    st_d.irq_stat[1] = 1'b1;
                end else begin
                    st_d.irq_stat[0] = 1'b1;
                end
            end
            default: ;
        endcase
        // write completes once both address and data are in
        if (do_wr) begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = 2'b00;
            if (st_q.awaddr == PSP_OFF_CMD) begin
                if (st_q.wstrb[0] && !busy &&
                    (st_q.wdata[PSP_CMD_WRITE] || st_q.wdata[PSP_CMD_READ])) begin
                    st_d.fsm = PSP_H_SETUP;
                    st_d.is_read = st_q.wdata[PSP_CMD_READ];
                end
            end else if (st_q.awaddr == PSP_OFF_WDATA) begin
                if (st_q.wstrb[0]) begin
                    st_d.wbyte = st_q.wdata[7:0];
                end
            end else if (st_q.awaddr == PSP_OFF_IRQ_MASK) begin
                if (st_q.wstrb[0]) begin
                    st_d.irq_mask = st_q.wdata[1:0];
                end
            end else if (st_q.awaddr != PSP_OFF_STATUS && st_q.awaddr != PSP_OFF_RDATA &&
                st_q.awaddr != PSP_OFF_IRQ_STAT) begin
                st_d.bresp = 2'b10;
            end
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        // read answer; irq status read clears sticky bits, new events win
        if (s_axi_arvalid && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = 2'b00;
            st_d.rdata = PSP_ZERO_WORD;
            if (s_axi_araddr == PSP_OFF_CMD) begin
                st_d.rdata = PSP_ZERO_WORD;
            end else if (s_axi_araddr == PSP_OFF_WDATA) begin
                st_d.rdata[7:0] = st_q.wbyte;
            end else if (s_axi_araddr == PSP_OFF_STATUS) begin
                st_d.rdata[0] = busy;
            end else if (s_axi_araddr == PSP_OFF_RDATA) begin
                st_d.rdata[7:0] = st_q.rbyte;
            end else if (s_axi_araddr == PSP_OFF_IRQ_STAT) begin
                st_d.rdata[1:0] = st_q.irq_stat;
                st_d.irq_stat = ev_done; // a new event wins over the clear
            end else if (s_axi_araddr == PSP_OFF_IRQ_MASK) begin
                st_d.rdata[1:0] = st_q.irq_mask;
            end else begin
                st_d.rresp = 2'b10;
            end
        end
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // pin drive: host must assert chip-select with the strobe
    assign pins.cs_n = !(st_q.fsm == PSP_H_STROBE);
    assign pins.wr_n = !(st_q.fsm == PSP_H_STROBE && !st_q.is_read);
    assign pins.rd_n = !(st_q.fsm == PSP_H_STROBE && st_q.is_read);
    assign pins.data_from_host = st_q.wbyte;
    assign pins.data_host_oe = st_q.fsm != PSP_H_IDLE && !st_q.is_read;
    assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
    assign s_axi_wready = !st_q.w_got && !st_q.bvalid;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;
    assign irq = |(st_q.irq_stat & st_q.irq_mask);
endmodule

//--- logic/psp_if.sv
// pin-level carrier between external processor and the slave port
`timescale 1ns/1ps
interface psp_if;
    logic rd_n;
    logic wr_n;
    logic cs_n;
    logic [7:0] data_from_host;
    logic data_host_oe;
    logic [7:0] data_from_dev;
    logic data_dev_oe;
    modport device (
        input rd_n, input wr_n, input cs_n, input data_from_host, input data_host_oe,
        output data_from_dev, output data_dev_oe
    );
    modport host (
        output rd_n, output wr_n, output cs_n, output data_from_host, output data_host_oe,
        input data_from_dev, input data_dev_oe
    );
endinterface

//--- logic/psp_pkg.sv
// shared constants and types for the parallel slave port
package psp_pkg;
    // control/status register bit positions
    localparam int PSP_BIT_RX_PENDING = 7;
    localparam int PSP_BIT_TX_PENDING = 6;
    localparam int PSP_BIT_RX_OVERRUN = 5;
    localparam int PSP_BIT_MODE_SEL = 4;
    localparam logic [7:0] PSP_CTRL_RESET = 8'h00;
    // host register byte offsets on the axi4-lite bus
    localparam logic [7:0] PSP_OFF_CMD = 8'h00;
    localparam logic [7:0] PSP_OFF_WDATA = 8'h04;
    localparam logic [7:0] PSP_OFF_STATUS = 8'h08;
    localparam logic [7:0] PSP_OFF_RDATA = 8'h0C;
    localparam logic [7:0] PSP_OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] PSP_OFF_IRQ_MASK = 8'h14;
    // host command bits
    localparam int PSP_CMD_WRITE = 0;
    localparam int PSP_CMD_READ = 1;
    // strobe low time in cycles of aclk
    localparam logic [7:0] PSP_STROBE_CYC = 8'h0A;
    localparam logic [1:0] PSP_SYNC_RESET = 2'h3;
    localparam logic [31:0] PSP_ZERO_WORD = 32'h0000_0000;
    typedef enum logic [1:0] {PSP_H_IDLE, PSP_H_SETUP, PSP_H_STROBE, PSP_H_HOLD} psp_hstate_t;
endpackage

//--- logic/psp_sync.sv
// two-flop synchroniser for one strobe level
`timescale 1ns/1ps
module psp_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic async_in,
    output logic sync_out
);
    import psp_pkg::*;
    logic [1:0] s_q;
    // first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= PSP_SYNC_RESET;
        end else begin
            s_q <= {s_q[0], async_in};
        end
    end
    assign sync_out = s_q[1];
endmodule

//--- verification/psp_sva.sv
// concurrent checks on the strobe and data lines joining the two port ends
`timescale 1ns/1ps
module psp_sva
    import psp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic cs_n,
    input wire logic [7:0] data_from_host,
    input wire logic data_host_oe,
    input wire logic [7:0] data_from_dev,
    input wire logic data_dev_oe
);
    logic [7:0] low_q;
    logic [7:0] low_d;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // length of the current chip-select low phase
    always_comb low_d = cs_n ? 8'h00 : low_q + 8'h01;
    always_ff @(posedge aclk) low_q <= aresetn ? low_d : 8'h00;
    // strobe shape and data ownership
    property p_strobe_len; $rose(cs_n) |-> low_q == PSP_STROBE_CYC; endproperty
    property p_wr_setup; $fell(wr_n) |-> $past(data_host_oe); endproperty
    property p_wr_data; !wr_n && !cs_n |-> data_host_oe && $stable(data_from_host); endproperty
    property p_wr_cs; $fell(wr_n) |-> $fell(cs_n); endproperty
    property p_rd_cs; $fell(rd_n) |-> $fell(cs_n); endproperty
    property p_rd_drive; $fell(rd_n) |-> ##[1:4] data_dev_oe; endproperty
    property p_no_clash; !(data_dev_oe && data_host_oe); endproperty
    property p_rd_release; rd_n [*3] |-> !data_dev_oe; endproperty
    property p_one_strobe; !(!rd_n && !wr_n); endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe low time wrong");
    a_wr_setup: assert property (p_wr_setup) else $error("write data not set up");
    a_wr_data: assert property (p_wr_data) else $error("write data moved");
    a_wr_cs: assert property (p_wr_cs) else $error("write without select");
    a_rd_cs: assert property (p_rd_cs) else $error("read without select");
    a_rd_drive: assert property (p_rd_drive) else $error("device silent on read");
    a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
    a_rd_release: assert property (p_rd_release) else $error("device drives idle bus");
    a_one_strobe: assert property (p_one_strobe) else $error("read and write together");
    // main traffic seen
    c_write: cover property ($rose(wr_n));
    c_read: cover property ($rose(rd_n));
    c_dev_drive: cover property (data_dev_oe);
endmodule

//--- verification/testbench.sv
// self-checking bench joining host and device ends of the slave port
`timescale 1ns/1ps
module testbench;
    import psp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ext_bus_active = 1'b0;
    logic ctrl_wr = 1'b0;
    logic data_wr = 1'b0;
    logic data_rd = 1'b0;
    logic [7:0] ctrl_wdata = 8'h00;
    logic [7:0] data_wdata = 8'h00;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [7:0] status, data_rdata, b;
    logic [31:0] s_axi_rdata, rd_word;
    logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, dev_irq;
    int miscompares = 0;
    int checked = 0;
    int irq_cnt = 0;
    int i;
    integer seed = 32'hEFFC;
    // clock and transfer counter
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) if (dev_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    psp_if i_psp_if (); // strobe lines are device inputs only
    psp_device i_psp_device (.aclk, .aresetn, .pins(i_psp_if), .ext_bus_active, .ctrl_wr,
        .ctrl_wdata, .slave_port_control_status(status), .data_wr, .data_wdata, .data_rd,
        .data_rdata, .slave_port_irq_flag(dev_irq));
    psp_host i_psp_host (.aclk, .aresetn, .pins(i_psp_if), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
    psp_sva i_psp_sva (.aclk, .aresetn, .rd_n(i_psp_if.rd_n), .wr_n(i_psp_if.wr_n),
        .cs_n(i_psp_if.cs_n), .data_from_host(i_psp_if.data_from_host),
        .data_host_oe(i_psp_if.data_host_oe), .data_from_dev(i_psp_if.data_from_dev),
        .data_dev_oe(i_psp_if.data_dev_oe));
    // expected control/status byte
    function automatic logic [7:0] exp_stat(input logic rx, input logic tx, input logic ov,
        input logic md);
        return {rx, tx, ov, md, 4'h0};
    endfunction
    task automatic summarize;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic lost;
        miscompares++;
        summarize();
    endtask
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
            miscompares++;
        end
    endtask
    // one axi4-lite write, address and data offered together
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 100) lost();
    endtask
    // one axi4-lite read
    task automatic axi_rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        rd_word = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 100) lost();
    endtask
    // one-cycle internal cpu pulse: bit0 control, bit1 data write, bit2 data read
    task automatic cpu(input logic [2:0] k, input logic [7:0] v);
        @(posedge aclk);
        ctrl_wr <= k[0];
        data_wr <= k[1];
        data_rd <= k[2];
        ctrl_wdata <= v;
        data_wdata <= v;
        @(posedge aclk);
        ctrl_wr <= 1'b0;
        data_wr <= 1'b0;
        data_rd <= 1'b0;
        #1;
    endtask
    task automatic wait_xfer(input int want);
        int n;
        for (n = 0; n < 200 && irq_cnt != want; n++) @(posedge aclk);
        #1;
        if (n == 200) lost();
    endtask
    task automatic wait_idle;
        int n;
        for (n = 0; n < 50; n++) begin
            axi_rd(PSP_OFF_STATUS);
            if (rd_word[0] === 1'b0) break;
        end
        if (n == 50) lost();
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        chk(exp_stat(0, 0, 0, 0), status);
        cpu(3'b001, 8'hFF);
        chk(exp_stat(0, 0, 0, 1), status);
        axi_rd(8'h40);
        chk(2'b10, rd_resp);
        axi_wr(8'h40, 32'h0);
        chk(2'b10, wr_resp);
        axi_wr(PSP_OFF_IRQ_MASK, 32'h2);
        // external writes, the third left unread to force an overrun
        for (i = 0; i < 4; i++) begin
            b = 8'($random(seed));
            axi_wr(PSP_OFF_WDATA, {24'h0, b});
            axi_wr(PSP_OFF_CMD, 32'h1);
            wait_xfer(i + 1);
            chk(b, data_rdata);
            chk(exp_stat(1, 0, i == 3, 1), status);
            chk(1'b0, irq);
            if (i != 2) cpu(3'b100, 8'h00);
            if (i != 2) chk(exp_stat(0, 0, i == 3, 1), status);
        end
        cpu(3'b001, 8'h10);
        chk(exp_stat(0, 0, 0, 1), status);
        axi_wr(PSP_OFF_IRQ_MASK, 32'h3);
        axi_rd(PSP_OFF_IRQ_MASK);
        chk(32'h3, rd_word);
        chk(1'b1, irq);
        axi_rd(PSP_OFF_IRQ_STAT);
        chk(32'h1, rd_word);
        axi_rd(PSP_OFF_IRQ_STAT);
        chk(32'h0, rd_word);
        chk(1'b0, irq);
        // external read of a cpu byte
        b = 8'($random(seed));
        cpu(3'b010, b);
        chk(exp_stat(0, 1, 0, 1), status);
        axi_wr(PSP_OFF_CMD, 32'h2);
        wait_xfer(5);
        chk(exp_stat(0, 0, 0, 1), status);
        axi_rd(PSP_OFF_RDATA);
        chk(b, rd_word[7:0]);
        axi_rd(PSP_OFF_IRQ_STAT);
        chk(32'h2, rd_word);
        // external bus active, then port mode off: writes must not land
        for (i = 0; i < 2; i++) begin
            ext_bus_active <= (i == 0);
            if (i == 1) cpu(3'b001, 8'h00);
            axi_wr(PSP_OFF_CMD, 32'h1);
            wait_idle();
            repeat (6) @(posedge aclk);
            chk(exp_stat(0, 0, 0, i == 0), status);
            chk(5, irq_cnt);
        end
        summarize();
    end
endmodule
